// ---- pkg/safe_stop_consts.vh ----
// constants for the timed safe stop controller
`ifndef SAFE_STOP_CONSTS_VH
`define SAFE_STOP_CONSTS_VH
// clock rate
`define CLK_HZ 100000000
// register byte offsets
`define REG_CTRL 8'h00
`define REG_DELAY 8'h04
`define REG_STATUS 8'h08
`define REG_FBUS 8'h0C
// control register fields
`define CTRL_FUNC_LSB 0
`define CTRL_FUNC_MSB 3
`define CTRL_RESTART_BIT 4
`define CTRL_FBUS_EN_BIT 5
`define CTRL_CLEAR_BIT 6
// safe input function value selecting the timed safe stop
`define FUNC_TIMED_STOP 4'h9
// fieldbus control byte: timed stop request bit, active low
`define FBUS_STOP_BIT 1
// reset values
`define CTRL_RESET 32'h00000000
`define DELAY_RESET 32'h00000001
`define FBUS_RESET 8'hFF
// times: test pulse filter 5 ms, discrepancy 0.5 s (500 ms), tick 1 ms
`define FILTER_MS 5
`define DISC_MS 500
`define TICK_CYCLES 100000
// countdown unit: delay register counts milliseconds
`define MS_PER_S 1000
`endif

// ---- rtl/ms_tick.v ----
// millisecond tick divider
`timescale 1ns/10ps
`default_nettype none
`include "safe_stop_consts.vh"
module ms_tick
#(
  parameter TICK_CYCLES = `TICK_CYCLES
)
(
  input wire aclk,
  input wire aresetn,
  output reg tick_ff
);
  // ----------------------------------------
  // divider
  // ----------------------------------------
  reg [16:0] cnt_ff; // cycle counter
  // one-cycle pulse every tick period
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_ff <= 17'h00000;
      tick_ff <= 1'b0;
    end
    else if (cnt_ff == TICK_CYCLES - 1)
    begin
      cnt_ff <= 17'h00000;
      tick_ff <= 1'b1;
    end
    else
    begin
      cnt_ff <= cnt_ff + 17'h00001;
      tick_ff <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/pulse_filter.v ----
// low test pulse filter for one safe input channel
`timescale 1ns/10ps
`default_nettype none
`include "safe_stop_consts.vh"
module pulse_filter
(
  input wire aclk,
  input wire aresetn,
  input wire tick,
  input wire raw_in,
  output reg filt_ff
);
  // ----------------------------------------
  // synchroniser and filter
  // ----------------------------------------
  reg s1_ff; // first stage, read only by s2
  reg s2_ff; // second stage
  reg [3:0] low_ms_ff; // milliseconds seen low
  // low must outlast the filter time before the channel reads low
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      low_ms_ff <= 4'h0;
      filt_ff <= 1'b1;
    end
    else
    begin
      s1_ff <= raw_in;
      s2_ff <= s1_ff;
      if (s2_ff)
      begin
        // high returns at once
        low_ms_ff <= 4'h0;
        filt_ff <= 1'b1;
      end
      else if (tick)
      begin
        if (low_ms_ff > `FILTER_MS)
          filt_ff <= 1'b0;
        else
          low_ms_ff <= low_ms_ff + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- rtl/timed_safe_stop.v ----
// timed safe stop controller with AXI4-Lite registers
// Summary of operation
// - safe inputs trigger only when function is 9
// - either low channel or fieldbus starts countdown
// - mismatch over 0.5 s raises warning
// - automatic mode clears countdown when all inactive
// - manual mode keeps countdown running
// - expiry removes torque and reports warning
// - any fault removes torque at once
// - fault before expiry coasts motor immediately
// - fieldbus commands accepted only when enabled
// - stop request is control bit 1, active low
// - countdown stays within the stated precision
// - low pulses up to 5 ms ignored
// - earlier valid channel drives the reaction
//
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "safe_stop_consts.vh"
module timed_safe_stop
#(
  parameter TICK_CYCLES = `TICK_CYCLES
)
(
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire safe_in_a,
  input wire safe_in_b,
  input wire fault_in,
  output reg torque_removal_ff,
  output reg decel_request_ff,
  output reg coast_ff,
  output reg channel_mismatch_warning_ff,
  output reg torque_removed_warning_ff
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_IDLE = 2'b00; // no stop pending
  localparam ST_TIMING = 2'b01; // countdown running
  localparam ST_REMOVED = 2'b10; // torque removed after expiry
  localparam ST_FAULT = 2'b11; // torque removed by fault
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  wire tick; // millisecond enable
  wire chan_a; // filtered channel a
  wire chan_b; // filtered channel b
  reg f1_ff; // fault synchroniser first stage
  reg fault_ff; // synchronised fault
  reg [31:0] ctrl_ff; // control register
  reg [31:0] delay_ff; // stop delay in milliseconds
  reg [7:0] fbus_ff; // latest fieldbus control byte
  reg [1:0] state_ff; // controller state
  reg [1:0] nxt_state;
  reg [31:0] cnt_ff; // elapsed milliseconds
  reg [9:0] disc_ff; // mismatch duration in milliseconds
  reg aw_hold_ff; // write address taken
  reg w_hold_ff; // write data taken
  reg [7:0] awaddr_ff; // latched write address
  reg [31:0] wdata_ff; // latched write data
  reg [3:0] wstrb_ff; // latched strobes
  wire di_sel; // safe inputs select timed stop
  wire fb_en; // fieldbus accepted
  wire fb_req; // fieldbus stop request
  wire di_req; // safe input stop request
  wire auto_mode; // automatic restart
  wire expired; // countdown reached the delay
  wire do_write; // both halves of a write held
  // ----------------------------------------
  // submodules
  // ----------------------------------------
  ms_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick_ff(tick)
  );
  pulse_filter u_filt_a
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .raw_in(safe_in_a),
    .filt_ff(chan_a)
  );
  pulse_filter u_filt_b
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .raw_in(safe_in_b),
    .filt_ff(chan_b)
  );
  // ----------------------------------------
  // request decode
  // ----------------------------------------
  assign di_sel = (ctrl_ff[`CTRL_FUNC_MSB:`CTRL_FUNC_LSB] == `FUNC_TIMED_STOP);
  assign fb_en = ctrl_ff[`CTRL_FBUS_EN_BIT];
  assign fb_req = fb_en & ~fbus_ff[`FBUS_STOP_BIT];
  assign di_req = di_sel & (~chan_a | ~chan_b);
  assign auto_mode = ctrl_ff[`CTRL_RESTART_BIT];
  assign expired = (cnt_ff >= delay_ff);
  assign do_write = aw_hold_ff & w_hold_ff & ~s_axi_bvalid;
  // ----------------------------------------
  // fault synchroniser
  // ----------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      f1_ff <= 1'b0;
      fault_ff <= 1'b0;
    end
    else
    begin
      f1_ff <= fault_in;
      fault_ff <= f1_ff;
    end
  end
  // ----------------------------------------
  // state transitions
  // ----------------------------------------
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (fault_ff)
          nxt_state = ST_FAULT;
        else if (di_req | fb_req)
          nxt_state = ST_TIMING;
      end
      ST_TIMING:
      begin
        if (fault_ff)
          nxt_state = ST_FAULT;
        else if (expired)
          nxt_state = ST_REMOVED;
        else if (auto_mode & ~fb_req & ~(di_sel & (~chan_a | ~chan_b)))
          nxt_state = ST_IDLE;
        else
          nxt_state = ST_TIMING;
      end
      ST_REMOVED:
      begin
        if (fault_ff)
          nxt_state = ST_FAULT;
        else if (~di_req & ~fb_req & (auto_mode | ctrl_ff[`CTRL_CLEAR_BIT]))
          nxt_state = ST_IDLE;
      end
      ST_FAULT:
      begin
        if (~fault_ff & ~di_req & ~fb_req & ctrl_ff[`CTRL_CLEAR_BIT])
          nxt_state = ST_IDLE;
      end
      default:
        nxt_state = ST_FAULT;
    endcase
  end
  // ----------------------------------------
  // state, countdown, outputs
  // ----------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_ff <= ST_IDLE;
      cnt_ff <= 32'h00000000;
      disc_ff <= 10'h000;
      torque_removal_ff <= 1'b0;
      decel_request_ff <= 1'b0;
      coast_ff <= 1'b0;
      channel_mismatch_warning_ff <= 1'b0;
      torque_removed_warning_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      // count only while timing, restart from zero otherwise
      if (nxt_state == ST_TIMING && state_ff == ST_TIMING)
      begin
        if (tick)
          cnt_ff <= cnt_ff + 32'h00000001;
      end
      else
        cnt_ff <= 32'h00000000;
      // mismatch duration between filtered channels
      if (chan_a == chan_b)
      begin
        disc_ff <= 10'h000;
        channel_mismatch_warning_ff <= 1'b0;
      end
      else if (tick)
      begin
        if (disc_ff >= `DISC_MS)
          channel_mismatch_warning_ff <= 1'b1;
        else
          disc_ff <= disc_ff + 10'h001;
      end
      torque_removal_ff <= (nxt_state == ST_REMOVED) | (nxt_state == ST_FAULT);
      torque_removed_warning_ff <= (nxt_state == ST_REMOVED) | (nxt_state == ST_FAULT);
      decel_request_ff <= (nxt_state == ST_TIMING);
      coast_ff <= (nxt_state == ST_FAULT);
    end
  end
  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      ctrl_ff <= `CTRL_RESET;
      delay_ff <= `DELAY_RESET;
      fbus_ff <= `FBUS_RESET;
    end
    else
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      // take address
      if (s_axi_awvalid & ~aw_hold_ff & ~s_axi_awready)
      begin
        s_axi_awready <= 1'b1;
        aw_hold_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      // take data
      if (s_axi_wvalid & ~w_hold_ff & ~s_axi_wready)
      begin
        s_axi_wready <= 1'b1;
        w_hold_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      // one-shot clear bit falls back after one cycle
      ctrl_ff[`CTRL_CLEAR_BIT] <= 1'b0;
      if (do_write)
      begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
        case (awaddr_ff & 8'hFC)
          `REG_CTRL:
          begin
            if (wstrb_ff[0])
              ctrl_ff[6:0] <= wdata_ff[6:0];
          end
          `REG_DELAY:
          begin
            if (wstrb_ff[0])
              delay_ff[7:0] <= wdata_ff[7:0];
            if (wstrb_ff[1])
              delay_ff[15:8] <= wdata_ff[15:8];
            if (wstrb_ff[2])
              delay_ff[23:16] <= wdata_ff[23:16];
            if (wstrb_ff[3])
              delay_ff[31:24] <= wdata_ff[31:24];
          end
          `REG_FBUS:
          begin
            if (wstrb_ff[0])
              fbus_ff <= wdata_ff[7:0];
          end
          `REG_STATUS:
            s_axi_bresp <= 2'b10;
          default:
            s_axi_bresp <= 2'b10;
        endcase
      end
      else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end
    else
    begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready)
      begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr & 8'hFC)
          `REG_CTRL:
            s_axi_rdata <= {25'h0, ctrl_ff[6:0]};
          `REG_DELAY:
            s_axi_rdata <= delay_ff;
          `REG_STATUS:
            s_axi_rdata <= {cnt_ff[23:0], chan_b, chan_a, coast_ff, channel_mismatch_warning_ff,
                            torque_removed_warning_ff, torque_removal_ff, state_ff};
          `REG_FBUS:
            s_axi_rdata <= {24'h000000, fbus_ff};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end
      else if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- test/tss_checker.sv ----
// port assertions for the timed safe stop controller
`timescale 1ns/10ps
`default_nettype none
module tss_checker
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic fault_in,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic torque_removal_ff,
  input wire logic coast_ff,
  input wire logic torque_removed_warning_ff
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // safety outputs
  // ----------------------------------------
  warn_mirror_a: assert property (torque_removed_warning_ff == torque_removal_ff)
    else $error("removed warning differs from torque removal");
  coast_torque_a: assert property ($rose(coast_ff) |-> torque_removal_ff)
    else $error("coast without torque removal");
  fault_stop_a: assert property (fault_in |-> ##[1:6] torque_removal_ff)
    else $error("fault did not remove torque");
  // ----------------------------------------
  // register bus handshakes
  // ----------------------------------------
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  w_pulse_a: assert property (s_axi_wready |=> !s_axi_wready)
    else $error("wready longer than one cycle");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed early");
  r_with_ar_a: assert property (s_axi_arready |-> s_axi_rvalid)
    else $error("rvalid not with arready");
  b_after_w_a: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_wready || s_axi_awready))
    else $error("bvalid not one cycle after the later write half");
endmodule
bind timed_safe_stop tss_checker chk
(
  .aclk(aclk), .aresetn(aresetn), .fault_in(fault_in),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .torque_removal_ff(torque_removal_ff), .coast_ff(coast_ff),
  .torque_removed_warning_ff(torque_removed_warning_ff)
);
`default_nettype wire

// ---- test/safe_plc.sv ----
// safety controller model driving the two safe input channels
`timescale 1ns/10ps
`default_nettype none
module safe_plc
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic req_a,
  input wire logic req_b,
  input wire logic test_en,
  output var logic safe_a_ff,
  output var logic safe_b_ff
);
  logic [7:0] cnt_ff; // test pattern period, 200 cycles
  wire pulse = test_en && (cnt_ff < 8'h1E); // 3 ms low test window
  // stop request or test pulse pulls a channel low
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_ff <= 8'h00;
      safe_a_ff <= 1'b1;
      safe_b_ff <= 1'b1;
    end
    else
    begin
      cnt_ff <= (cnt_ff == 8'hC7) ? 8'h00 : cnt_ff + 8'h01;
      safe_a_ff <= !(req_a || pulse);
      safe_b_ff <= !(req_b || pulse);
    end
  end
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// self-checking bench for the timed safe stop controller
`timescale 1ns/10ps
`default_nettype none
`include "safe_stop_consts.vh"
module tb_top;
  logic aclk, aresetn, fault_in, req_a, req_b, test_en, safe_a, safe_b;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic torque, decel, coast, mismatch, warn;
  integer fails, checks_done, cycles, n;
  // 1 ms is 10 cycles here
  timed_safe_stop #(.TICK_CYCLES(10)) dut
  (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .safe_in_a(safe_a), .safe_in_b(safe_b),
    .fault_in, .torque_removal_ff(torque), .decel_request_ff(decel), .coast_ff(coast),
    .channel_mismatch_warning_ff(mismatch), .torque_removed_warning_ff(warn)
  );
  safe_plc plc
  (
    .aclk, .aresetn, .req_a, .req_b, .test_en, .safe_a_ff(safe_a), .safe_b_ff(safe_b)
  );
  // ----------------------------------------
  // clock, watchdog, report
  // ----------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cycles = cycles + 1;
    if (cycles == 40000)
    begin
      fails = fails + 1;
      tally_and_finish;
    end
  end
  task tally_and_finish;
    begin
      $display("checks=%0d fails=%0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // ----------------------------------------
  // compare and bus tasks
  // ----------------------------------------
  function [31:0] z(input logic b);
    z = {31'h0, b};
  endfunction
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    begin
      checks_done = checks_done + 1;
      if (g !== e)
      begin
        fails = fails + 1;
        $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task automatic wt(input integer c);
    repeat (c) @(posedge aclk);
  endtask
  // write: address and data together, bready one cycle late
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do
      begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
      @(posedge aclk);
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      cmp({30'h0, s_axi_bresp}, {30'h0, er});
    end
  endtask
  // read: rready raised after the address is taken
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      cmp(s_axi_rdata, ed);
      cmp({30'h0, s_axi_rresp}, {30'h0, er});
    end
  endtask
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial
  begin
    fails = 0;
    checks_done = 0;
    cycles = 0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {fault_in, req_a, req_b, test_en} = 4'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`REG_CTRL, 32'h00000000, 2'h0);
    rd(`REG_DELAY, 32'h00000001, 2'h0);
    rd(`REG_FBUS, 32'h000000FF, 2'h0);
    rd(`REG_STATUS, 32'h000000C0, 2'h0);
    rd(8'h10, 32'h00000000, 2'h2);
    wr(`REG_STATUS, 32'h00000000, 2'h2);
    // function other than 9 ignores the inputs
    req_a <= 1'b1;
    req_b <= 1'b1;
    wt(150);
    cmp(z(decel), 32'h0);
    req_a <= 1'b0;
    req_b <= 1'b0;
    // let the filtered channels return high before function 9 is selected
    wt(10);
    wr(`REG_CTRL, 32'h00000009, 2'h0);
    wr(`REG_DELAY, 32'h000003E8, 2'h0);
    test_en <= 1'b1;
    wt(600);
    cmp(z(decel), 32'h0);
    test_en <= 1'b0;
    wt(20);
    // both low, manual mode, 1 s delay
    req_a <= 1'b1;
    req_b <= 1'b1;
    n = 0;
    while (!decel)
    begin
      @(posedge aclk);
      n = n + 1;
    end
    cmp(z(n > 50 && n < 80), 32'h1);
    n = 0;
    while (!torque)
    begin
      @(posedge aclk);
      n = n + 1;
      if (n == 100) {req_a, req_b} <= 2'h0;
    end
    cmp(z(n >= 9990 && n <= 10510), 32'h1);
    cmp(z(warn), 32'h1);
    cmp(z(coast), 32'h0);
    wr(`REG_CTRL, 32'h00000059, 2'h0);
    wt(10);
    cmp(z(torque), 32'h0);
    // one channel only, automatic mode
    req_a <= 1'b1;
    wt(4900);
    cmp(z(decel), 32'h1);
    cmp(z(mismatch), 32'h0);
    wt(300);
    cmp(z(mismatch), 32'h1);
    req_a <= 1'b0;
    wt(80);
    cmp(z(decel), 32'h0);
    cmp(z(mismatch), 32'h0);
    cmp(z(torque), 32'h0);
    // fieldbus disabled, then enabled
    wr(`REG_CTRL, 32'h00000019, 2'h0);
    wr(`REG_FBUS, 32'h000000FD, 2'h0);
    wt(20);
    cmp(z(decel), 32'h0);
    wr(`REG_CTRL, 32'h00000039, 2'h0);
    wt(20);
    cmp(z(decel), 32'h1);
    wr(`REG_FBUS, 32'h000000FF, 2'h0);
    wt(20);
    cmp(z(decel), 32'h0);
    wr(`REG_FBUS, 32'h000000FE, 2'h0);
    wt(20);
    cmp(z(decel), 32'h0);
    // fault during countdown
    wr(`REG_FBUS, 32'h000000FD, 2'h0);
    wt(20);
    cmp(z(decel), 32'h1);
    fault_in <= 1'b1;
    wt(8);
    cmp(z(torque), 32'h1);
    cmp(z(coast), 32'h1);
    fault_in <= 1'b0;
    wr(`REG_FBUS, 32'h000000FF, 2'h0);
    wr(`REG_CTRL, 32'h00000079, 2'h0);
    wt(10);
    cmp(z(torque), 32'h0);
    cmp(z(coast), 32'h0);
    // both channels held low for 1 s, automatic mode, 500 ms delay
    wr(`REG_DELAY, 32'h000001F4, 2'h0);
    {req_a, req_b} <= 2'h3;
    wt(10000);
    cmp(z(torque), 32'h1);
    cmp(z(mismatch), 32'h0);
    {req_a, req_b} <= 2'h0;
    wt(20);
    cmp(z(torque), 32'h0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
